// *** logic/secondary_cache_control.sv ***
// Purpose: Control of a direct-mapped write-through secondary cache
// Assumes: All bus pins come from outside and are double-registered
// Notes: Module reset is the synchronous reset pin; rst_b is power-on only
`timescale 1ns/1ps
`include "cache_ctl_params.svh"
module secondary_cache_control (
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic rst_b,
  // Module control
  input wire logic reset_pin,
  input wire logic flush_n,
  input wire logic chip_select_n,
  // Processor cycle
  input wire logic address_strobe_n,
  input wire logic snoop_strobe_n,
  input wire logic mem_io,
  input wire logic write_read,
  input wire logic [`ADDR_W-1:0] address,
  input wire logic [3:0] byte_lane_enable_n,
  input wire logic last_transfer_n,
  input wire logic write_protect,
  // Memory system
  input wire logic mem_burst_ready_in_n,
  input wire logic mem_single_ready_in_n,
  input wire logic system_cacheable_n,
  input wire logic bus_backoff_n,
  // Data bus pins
  input wire cache_ctl_pkg::bus_word_t data_in,
  output cache_ctl_pkg::bus_word_t data_out,
  output logic data_oe,
  // Handshake outputs
  output logic mem_start_n,
  output logic cache_burst_ready_out_n,
  output logic cpu_cacheable_n,
  output logic presence_n
);
  import cache_ctl_pkg::*;

  // Two-flop input synchronisers
  localparam int SW = 14 + `ADDR_W + 4 + 36;
  logic [SW-1:0] sync1, sync2;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1 <= '1;
      sync2 <= '1;
    end else begin
      sync1 <= {reset_pin, flush_n, chip_select_n, address_strobe_n, snoop_strobe_n,
        mem_io, write_read, last_transfer_n, write_protect, mem_burst_ready_in_n,
        mem_single_ready_in_n, system_cacheable_n, bus_backoff_n, 1'b0,
        address, byte_lane_enable_n, data_in};
      sync2 <= sync1;
    end
  end
  logic s_reset, s_flush_n, s_cs_n, s_ads_n, s_snoop_strobe_n_n, s_mio, s_wr, s_last_transfer_n_n, s_wp;
  logic s_mem_burst_ready_in_n_n, s_mem_single_ready_in_n_n, s_system_cacheable_n_n, s_bus_backoff_n_n, s_unused;
  logic [`ADDR_W-1:0] s_addr;
  logic [3:0] s_be_n;
  bus_word_t s_data;
  assign {s_reset, s_flush_n, s_cs_n, s_ads_n, s_snoop_strobe_n_n, s_mio, s_wr, s_last_transfer_n_n, s_wp,
    s_mem_burst_ready_in_n_n, s_mem_single_ready_in_n_n, s_system_cacheable_n_n, s_bus_backoff_n_n, s_unused, s_addr, s_be_n, s_data} = sync2;

  ctl_state_t state;
  logic [`ADDR_W-1:0] lat_addr;
  logic [1:0] hold_cnt;
  logic [1:0] word;
  logic [2:0] fill_cnt;
  logic system_cacheable_n_first, system_cacheable_n_ok;
  logic hit;
  bus_word_t rd_word;
  logic mem_rdy;

  logic snoop_go, cpu_go, idle_ok;
  assign idle_ok = (state == ST_IDLE) && (hold_cnt == 2'h0);
  assign snoop_go = idle_ok && !s_snoop_strobe_n_n && !s_cs_n;
  assign cpu_go = idle_ok && !s_ads_n && !s_cs_n && s_snoop_strobe_n_n && s_bus_backoff_n_n;
  assign mem_rdy = !s_mem_burst_ready_in_n_n || !s_mem_single_ready_in_n_n;
  // Burst stops after a full line even if last transfer arrives late
  logic hit_more;
  assign hit_more = (state == ST_HIT_BURST) && s_last_transfer_n_n && (word != lat_addr[1:0]);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lat_addr <= '0;
      hold_cnt <= 2'h0;
    end else if (s_reset) begin
      hold_cnt <= 2'h0;
    end else if (snoop_go) begin
      lat_addr <= s_addr;
      hold_cnt <= `INVAL_HOLD;
    end else if (cpu_go) begin
      lat_addr <= s_addr;
      hold_cnt <= `IO_HOLD;
    end else if (hold_cnt != 2'h0) begin
      hold_cnt <= hold_cnt - 2'h1;
    end
  end

  // Lookup address: latched outside ST_IDLE, live in ST_IDLE
  logic [`ADDR_W-1:0] look;
  assign look = (state == ST_IDLE) ? s_addr : lat_addr;

  // Controller state
  logic next_is_io;
  assign next_is_io = !s_mio;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
    end else if (s_reset) begin
      state <= ST_IDLE;
    end else if (!s_bus_backoff_n_n) begin
      state <= snoop_go ? ST_INVAL : ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (snoop_go) begin
            state <= ST_INVAL;
          end else if (cpu_go) begin
            state <= ST_LOOKUP;
          end
        end
        ST_LOOKUP: begin
          if (s_wr) begin
            state <= ST_WRITE;
          end else if (!next_is_io && hit) begin
            state <= ST_HIT_BURST;
          end else begin
            state <= ST_MISS;
          end
        end
        ST_HIT_BURST: begin
          if (!hit_more) begin
            state <= ST_IDLE;
          end
        end
        ST_MISS: begin
          if (mem_rdy && (!s_last_transfer_n_n || fill_cnt == `LINE_WORDS - 3'h1)) begin
            state <= ST_IDLE;
          end
        end
        ST_WRITE: begin
          state <= ST_IDLE;
        end
        ST_INVAL: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      word <= 2'h0;
    end else if (state == ST_LOOKUP) begin
      // First hit word leaves from lookup, so the burst resumes at the next one
      word <= lat_addr[1:0] + {1'b0, !s_wr && s_mio && hit};
    end else if (hit_more) begin
      word <= word + 2'h1;
    end else if (state == ST_MISS && mem_rdy) begin
      word <= word + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fill_cnt <= 3'h0;
      system_cacheable_n_first <= 1'b0;
      system_cacheable_n_ok <= 1'b0;
    end else if (state != ST_MISS) begin
      fill_cnt <= 3'h0;
      system_cacheable_n_first <= 1'b0;
      system_cacheable_n_ok <= 1'b0;
    end else begin
      if (mem_rdy) begin
        fill_cnt <= fill_cnt + 3'h1;
      end
      if (fill_cnt == 3'h0 && !mem_rdy && !s_system_cacheable_n_n) begin
        system_cacheable_n_first <= 1'b1;
      end
      if (fill_cnt == `LINE_WORDS - 3'h1 && !mem_rdy) begin
        system_cacheable_n_ok <= !s_system_cacheable_n_n && system_cacheable_n_first;
      end
    end
  end

  // Storage updates
  logic clear_all, set_valid, clr_valid, wr_en;
  logic [3:0] wr_lane;
  logic miss_cacheable;
  assign miss_cacheable = (state == ST_MISS) && s_mio && system_cacheable_n_first;
  assign clear_all = s_reset || !s_flush_n;
  assign set_valid = miss_cacheable && mem_rdy && (fill_cnt == `LINE_WORDS - 3'h1)
    && (system_cacheable_n_ok || !s_system_cacheable_n_n) && s_last_transfer_n_n == 1'b0;
  assign clr_valid = ((state == ST_INVAL) && hit)
    || ((state == ST_MISS) && s_mio && fill_cnt == 3'h0 && !s_system_cacheable_n_n && !mem_rdy);
  always_comb begin
    wr_lane = 4'h0;
    wr_en = 1'b0;
    if (state == ST_WRITE && hit && s_mio && !s_wp) begin
      wr_en = 1'b1;
      wr_lane = ~s_be_n;
    end else if (miss_cacheable && mem_rdy) begin
      wr_en = 1'b1;
      wr_lane = 4'hF;
    end
  end

  line_store u_store (
    .mclk(mclk),
    .rst_b(rst_b),
    .clear_all(clear_all),
    .index(look[`TAG_LSB-1:`IDX_LSB]),
    .tag(look[`ADDR_W-1:`TAG_LSB]),
    .word((state == ST_IDLE || state == ST_LOOKUP) ? look[1:0] : word),
    .hit(hit),
    .rd_word(rd_word),
    .set_valid(set_valid),
    .clr_valid(clr_valid),
    .wr_en(wr_en),
    .wr_lane(wr_lane),
    .wr_word(s_data)
  );

  // Registered pin outputs
  logic next_burst;
  assign next_burst = (state == ST_LOOKUP) && !s_wr && s_mio && hit;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      mem_start_n <= 1'b1;
      cache_burst_ready_out_n <= 1'b1;
      cpu_cacheable_n <= 1'b0;
      data_oe <= 1'b0;
      data_out <= '0;
      presence_n <= 1'b0;
    end else begin
      presence_n <= 1'b0;
      if (s_reset || !s_bus_backoff_n_n) begin
        mem_start_n <= 1'b1;
        cache_burst_ready_out_n <= 1'b1;
        cpu_cacheable_n <= 1'b0;
        data_oe <= 1'b0;
      end else begin
        mem_start_n <= !((state == ST_LOOKUP) && (s_wr || !hit || !s_mio));
        cache_burst_ready_out_n <= !(next_burst || hit_more);
        data_oe <= next_burst || hit_more;
        data_out <= rd_word;
        cpu_cacheable_n <= !(cpu_go || next_burst || hit_more || state == ST_IDLE);
      end
    end
  end
endmodule

// *** logic/cache_ctl_params.svh ***
// Purpose: Named constants for the secondary cache controller
// Assumes: 50 MHz mclk, direct-mapped 128 KB cache of 16-byte lines
// Notes: Widths follow the processor bus
`ifndef CACHE_CTL_PARAMS_SVH
`define CACHE_CTL_PARAMS_SVH
`define ADDR_W 30
`define IDX_W 13
`define IDX_LSB 2
`define TAG_LSB 15
`define TAG_W 15
`define WORD_LSB 0
`define LINE_WORDS 3'h4
`define LAST_WORD 2'h3
`define INVAL_HOLD 2'h2
`define IO_HOLD 2'h1
`endif

// *** logic/cache_ctl_pkg.sv ***
// Purpose: Types shared by the cache controller files
// Assumes: cache_ctl_params.svh supplies widths
// Notes: Types only
`include "cache_ctl_params.svh"
package cache_ctl_pkg;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] par;
  } bus_word_t;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LOOKUP = 6'h02,
    ST_HIT_BURST = 6'h04,
    ST_MISS = 6'h08,
    ST_WRITE = 6'h10,
    ST_INVAL = 6'h20
  } ctl_state_t;
endpackage

// *** logic/line_store.sv ***
// Purpose: Tag, valid and data storage of the direct-mapped cache
// Assumes: Single mclk domain; writes take effect at the edge
// Notes: Valid bits clear in one cycle on reset or flush
`timescale 1ns/1ps
`include "cache_ctl_params.svh"
module line_store (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Invalidate all
  input wire logic clear_all,
  // Lookup
  input wire logic [`IDX_W-1:0] index,
  input wire logic [`TAG_W-1:0] tag,
  input wire logic [1:0] word,
  output logic hit,
  output cache_ctl_pkg::bus_word_t rd_word,
  // Updates
  input wire logic set_valid,
  input wire logic clr_valid,
  input wire logic wr_en,
  input wire logic [3:0] wr_lane,
  input wire cache_ctl_pkg::bus_word_t wr_word
);
  import cache_ctl_pkg::*;
  localparam int LINES = 1 << `IDX_W;
  logic [LINES-1:0] valid;
  logic [`TAG_W-1:0] tags [LINES];
  logic [7:0] bytes [4][LINES*4];
  logic parity [4][LINES*4];
  logic [`IDX_W+1:0] wa;

  assign wa = {index, word};
  assign hit = valid[index] && (tags[index] == tag);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      valid <= '0;
    end else if (clear_all) begin
      valid <= '0;
    end else if (set_valid) begin
      valid[index] <= 1'b1;
    end else if (clr_valid) begin
      valid[index] <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (set_valid || clr_valid) begin
      tags[index] <= tag;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      always_ff @(posedge mclk) begin
        if (wr_en && wr_lane[g]) begin
          bytes[g][wa] <= wr_word.data[8*g +: 8];
          parity[g][wa] <= wr_word.par[g];
        end
      end
      assign rd_word.data[8*g +: 8] = bytes[g][wa];
      assign rd_word.par[g] = parity[g][wa];
    end
  endgenerate
endmodule

// *** bench/cache_ctl_sva.sv ***
// Purpose: Pin checks of the cache controller
// Assumes: Inputs reach the logic two cycles late
// Notes: Bound to each controller
`timescale 1ns/1ps
module cache_ctl_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Pins
  input wire logic reset_pin,
  input wire logic chip_select_n,
  input wire logic address_strobe_n,
  input wire logic snoop_strobe_n,
  input wire logic mem_io,
  input wire logic write_read,
  input wire logic bus_backoff_n,
  input wire logic data_oe,
  input wire logic mem_start_n,
  input wire logic cache_burst_ready_out_n,
  input wire logic cpu_cacheable_n,
  input wire logic presence_n
);
  logic req;
  logic quiet;
  assign req = !address_strobe_n && !chip_select_n && snoop_strobe_n;
  assign quiet = mem_start_n && cache_burst_ready_out_n;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence backoff_held;
    !bus_backoff_n [*4];
  endsequence
  sequence pin_reset;
    reset_pin [*5];
  endsequence
  presence_low_a: assert property (!presence_n)
    else $error("presence high");
  start_pulse_a: assert property (!mem_start_n |=> mem_start_n)
    else $error("start too long");
  start_cause_a: assert property ($fell(mem_start_n) |-> $past(req, 4))
    else $error("start without strobe");
  hit_cause_a: assert property (
    $fell(cache_burst_ready_out_n) |-> $past(req && mem_io && !write_read, 4))
    else $error("burst without read");
  ready_drive_a: assert property (!cache_burst_ready_out_n |-> data_oe)
    else $error("ready without data");
  burst_len_a: assert property (
    !cache_burst_ready_out_n [*4] |=> cache_burst_ready_out_n)
    else $error("burst too long");
  backoff_idle_a: assert property (
    backoff_held |-> !data_oe && quiet && !cpu_cacheable_n)
    else $error("busy in backoff");
  reset_idle_a: assert property (pin_reset |=> quiet && !data_oe)
    else $error("busy after reset");
  miss_no_enable_a: assert property (!mem_start_n |-> cpu_cacheable_n)
    else $error("cache enable on miss");
endmodule
bind secondary_cache_control cache_ctl_sva cache_ctl_sva_i (.mclk, .rst_b, .reset_pin,
  .chip_select_n, .address_strobe_n, .snoop_strobe_n, .mem_io, .write_read,
  .bus_backoff_n, .data_oe, .mem_start_n, .cache_burst_ready_out_n, .cpu_cacheable_n,
  .presence_n);

// *** bench/mem_system_model.sv ***
// Purpose: Memory system behind the controller
// Assumes: Reads fill four words, writes end on one single ready
// Notes: slow delays the first word
`timescale 1ns/1ps
module mem_system_model
  import cache_ctl_pkg::*;
#(
  parameter logic [31:0] BASE = 32'hA5A5_0000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Requests
  input wire logic mem_start_n,
  input wire logic write_read,
  input wire logic slow,
  // Answers
  output bus_word_t mem_word,
  output logic mem_drive,
  output logic mem_burst_ready_in_n,
  output logic mem_single_ready_in_n,
  output logic system_cacheable_n,
  output logic fill_last_n
);
  logic busy;
  logic is_wr;
  logic [4:0] cnt;
  logic [4:0] beat;
  logic [35:0] word;
  assign beat = cnt - (slow ? 5'h6 : 5'h1);
  assign word = {BASE + 32'(beat), beat[3:0]};
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      cnt <= 5'h0;
      is_wr <= 1'b0;
    end else if (!busy) begin
      busy <= !mem_start_n;
      cnt <= 5'h0;
      is_wr <= write_read;
    end else begin
      cnt <= cnt + 5'h1;
      busy <= beat != 5'h4;
    end
  end
  assign mem_drive = busy && !is_wr && beat < 5'h4;
  assign mem_burst_ready_in_n = !mem_drive;
  // write ends on one single ready
  assign mem_single_ready_in_n = !(busy && is_wr && beat == 5'h0);
  // cacheable from the cycle before the first word
  assign system_cacheable_n = !(busy && !is_wr && (beat < 5'h4 || beat == 5'h1F));
  // last transfer with the final word
  assign fill_last_n = !(mem_drive && beat == 5'h3) && mem_single_ready_in_n;
  // A released bus shows the inverse, not the last value
  assign mem_word = mem_drive ? word : ~word;
endmodule

// *** bench/test_secondary_cache_control.sv ***
// Purpose: Self-checking bench of the cache controller
// Assumes: Memory model answers every start
// Notes: Line data follows the model pattern
`timescale 1ns/1ps
`include "cache_ctl_params.svh"
module test_secondary_cache_control;
  import cache_ctl_pkg::*;
  // Cycle kinds: write, memory, select_n, snoop_n, strobe_n
  localparam logic [4:0] RD = 5'h0A, WR = 5'h1A, IO_RD = 5'h02, NOSEL = 5'h0E;
  localparam logic [4:0] SNP_RD = 5'h08, SNP_NOSEL = 5'h0D;
  localparam logic [31:0] BASE = 32'hA5A5_0000;
  logic mclk = 1'b0, rst_b = 1'b0, reset_pin = 1'b1, flush_n = 1'b1;
  logic chip_select_n = 1'b1, address_strobe_n = 1'b1, snoop_strobe_n = 1'b1;
  logic mem_io = 1'b1, write_read = 1'b0, write_protect = 1'b0, bus_backoff_n = 1'b1;
  logic cpu_last_n = 1'b1, slow = 1'b0;
  logic [3:0] byte_lane_enable_n = 4'hF;
  logic [`ADDR_W-1:0] address = 30'h0000_1230;
  bus_word_t cpu_word = 36'h0, mem_word, data_in, data_out;
  bus_word_t got [4];
  logic last_transfer_n, mem_drive, mem_burst_ready_in_n, mem_single_ready_in_n;
  logic system_cacheable_n, fill_last_n, data_oe, mem_start_n;
  logic cache_burst_ready_out_n, cpu_cacheable_n, presence_n;
  int fails = 0, n_checks = 0;
  // Processor drives the bus only in writes, never against memory
  assign data_in = (write_read && !mem_drive) ? cpu_word : mem_word;
  assign last_transfer_n = cpu_last_n & fill_last_n;
  always #10 mclk = ~mclk;
  secondary_cache_control secondary_cache_control_i (.mclk, .rst_b, .reset_pin, .flush_n,
    .chip_select_n, .address_strobe_n, .snoop_strobe_n, .mem_io, .write_read, .address,
    .byte_lane_enable_n, .last_transfer_n, .write_protect, .mem_burst_ready_in_n,
    .mem_single_ready_in_n, .system_cacheable_n, .bus_backoff_n, .data_in, .data_out,
    .data_oe, .mem_start_n, .cache_burst_ready_out_n, .cpu_cacheable_n, .presence_n);
  mem_system_model mem_system_model_i (.mclk, .rst_b, .mem_start_n, .write_read, .slow,
    .mem_word, .mem_drive, .mem_burst_ready_in_n, .mem_single_ready_in_n,
    .system_cacheable_n, .fill_last_n);
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One cycle, then count starts and ready beats over a fixed window
  task automatic cyc(input logic [4:0] k, input logic [3:0] be_n, input int e_st, e_bt);
    int st;
    int bt;
    st = 0;
    bt = 0;
    @(posedge mclk);
    {write_read, mem_io, chip_select_n, snoop_strobe_n, address_strobe_n} <= k;
    byte_lane_enable_n <= be_n;
    @(posedge mclk);
    address_strobe_n <= 1'b1;
    snoop_strobe_n <= 1'b1;
    repeat (24) begin
      @(negedge mclk);
      if (mem_start_n === 1'b0) st++;
      if (cache_burst_ready_out_n === 1'b0) begin
        got[bt % 4] = data_out;
        bt++;
      end
      @(posedge mclk);
      cpu_last_n <= (bt != 3);
    end
    chip_select_n <= 1'b1;
    chk(36'(st), 36'(e_st));
    chk(36'(bt), 36'(e_bt));
    $display("cycle %h done: starts %0d beats %0d", k, st, bt);
  endtask
  task automatic line(input bus_word_t w0);
    for (int i = 0; i < 4; i++)
      chk(got[i], i == 0 ? w0 : {BASE + 32'(i), 4'(i)});
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    reset_pin <= 1'b0;
    repeat (4) @(negedge mclk);
    chk(36'({presence_n, mem_start_n, cache_burst_ready_out_n, data_oe}), 36'h6);
    cyc(RD, 4'hF, 1, 0);
    cyc(RD, 4'hF, 0, 4);
    line({BASE, 4'h0});
    cpu_word <= {32'h0000_003C, 4'hF};
    write_protect <= 1'b1;
    cyc(WR, 4'hE, 1, 0);
    cpu_word <= {32'h0000_7700, 4'hF};
    write_protect <= 1'b0;
    cyc(WR, 4'hD, 1, 0);
    cyc(RD, 4'hF, 0, 4);
    line({BASE | 32'h0000_7700, 4'h2});
    address <= 30'h0000_2340;
    slow <= 1'b1;
    cyc(IO_RD, 4'hF, 1, 0);
    cyc(RD, 4'hF, 1, 0);
    slow <= 1'b0;
    cyc(NOSEL, 4'hF, 0, 0);
    cyc(SNP_NOSEL, 4'hF, 0, 0);
    cyc(RD, 4'hF, 0, 4);
    cyc(SNP_RD, 4'hF, 0, 0);
    cyc(RD, 4'hF, 1, 0);
    bus_backoff_n <= 1'b0;
    cyc(RD, 4'hF, 0, 0);
    bus_backoff_n <= 1'b1;
    flush_n <= 1'b0;
    repeat (3) @(posedge mclk);
    flush_n <= 1'b1;
    cyc(RD, 4'hF, 1, 0);
    reset_pin <= 1'b1;
    flush_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_pin <= 1'b0;
    flush_n <= 1'b1;
    address <= 30'h0000_1230;
    repeat (3) @(posedge mclk);
    cyc(RD, 4'hF, 1, 0);
    end_sim;
  end
endmodule
